// *** verilog/lpv_pkg.sv ***
/*
  Constants for the link status, physical tuning and product data register slice.
  Assumes a 125 MHz core clock and a synchronous active-high reset.
*/
package lpv_pkg;
  localparam logic [7:0] LPV_OFS_LINK = 8'hC0;
  localparam logic [7:0] LPV_OFS_CFG0 = 8'hCC;
  localparam logic [7:0] LPV_OFS_CFG1 = 8'hD0;
  localparam logic [7:0] LPV_OFS_CFG2 = 8'hD4;
  localparam logic [7:0] LPV_OFS_CAP = 8'hD8;
  localparam logic [7:0] LPV_OFS_DATA = 8'hDC;
  localparam logic [7:0] LPV_OFS_DATA_ALIAS = 8'hEC;

  localparam logic [31:0] LPV_CFG0_RST = 32'h0400_1060;
  localparam logic [31:0] LPV_CFG1_RST = 32'h0400_0800;
  localparam logic [31:0] LPV_CFG2_RST = 32'h0099_8254;
  localparam logic [31:0] LPV_CFG2_WMASK = 32'h00FF_FFFF;
  localparam logic [31:0] LPV_DATA_RST = 32'h0000_0000;

  localparam logic [3:0] LPV_SPEED_RST = 4'h1;
  localparam logic [5:0] LPV_WIDTH_RST = 6'h01;
  localparam int LPV_SPEED_LSB = 16;
  localparam int LPV_WIDTH_LSB = 20;
  localparam int LPV_TRAIN_ERR_BIT = 26;
  localparam int LPV_TRAINING_BIT = 27;
  localparam int LPV_SLOT_CLK_BIT = 28;
  localparam int LPV_DL_INACTIVE_BIT = 29;

  localparam int LPV_PD_WAIT_BIT = 23;
  localparam logic [7:0] LPV_CAP_ID = 8'h03;
  localparam logic [7:0] LPV_NEXT_PTR = 8'hF0;
  localparam int LPV_OP_BIT = 31;
  localparam int LPV_ADDR_LSB = 18;
  localparam int LPV_ADDR_MSB = 23;

  localparam logic [7:0] LPV_EEP_BASE = 8'h40;
  localparam logic [1:0] LPV_EEP_OP_READ = 2'h2;
  localparam logic [1:0] LPV_EEP_OP_WRITE = 2'h1;
  localparam logic [5:0] LPV_EEP_HDR_BITS = 6'h0A;
  localparam logic [5:0] LPV_EEP_FRAME_BITS = 6'h2A;

  localparam int LPV_CLK_MHZ = 125;
  localparam int LPV_SCK_HALF_NS = 80;
  localparam int LPV_SCK_HALF_CYC = (LPV_SCK_HALF_NS * LPV_CLK_MHZ + 999) / 1000;
  localparam int LPV_PD_WAIT_NS = 1000;
  localparam int LPV_PD_WAIT_CYC = (LPV_PD_WAIT_NS * LPV_CLK_MHZ + 999) / 1000;
endpackage : lpv_pkg

// *** verilog/lpv_eep_if.sv ***
/*
  Request and answer signals between the register slice and the EEPROM engine.
  Assumes both ends run on the same core clock.
*/
interface lpv_eep_if;
  logic start;
  logic write;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic busy;
  logic done;
  logic [31:0] rdata;
  modport regs (output start, output write, output addr, output wdata,
                input busy, input done, input rdata);
  modport engine (input start, input write, input addr, input wdata,
                  output busy, output done, output rdata);
endinterface : lpv_eep_if

// *** verilog/lpv_sync3.sv ***
/*
  Three-flop input synchroniser; output follows once stages two and three agree.
  Assumes an asynchronous input and the core clock.
*/
module lpv_sync3 (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic async_i,
  output logic sync_o
);
  logic s1_q;
  logic s2_q;
  logic s3_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= async_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync_o <= 1'b0;
    end else if (s2_q == s3_q) begin
      sync_o <= s3_q;
    end
  end
endmodule // lpv_sync3

// *** verilog/lpv_eep_engine.sv ***
/*
  Serial EEPROM engine: sends opcode, address and data, or reads a word back.
  Assumes a synchronised data-in and start only while not busy.
*/
module lpv_eep_engine
  import lpv_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  lpv_eep_if.engine req,
  input wire logic eep_di_i,
  output logic eep_cs_o,
  output logic eep_sck_o,
  output logic eep_do_o
);
  typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_DONE} lpv_eep_state_type;
  localparam logic [7:0] HALF_CNT = 8'(LPV_SCK_HALF_CYC - 1);

  lpv_eep_state_type state_q;
  logic [7:0] div_q;
  logic tick;
  logic [41:0] tx_q;
  logic [31:0] rx_q;
  logic [5:0] cnt_q;
  logic wr_q;

  assign tick = (div_q == HALF_CNT);
  assign req.busy = (state_q != ST_IDLE);
  assign req.done = (state_q == ST_DONE);
  assign req.rdata = rx_q;
  assign eep_do_o = tx_q[41];

  // Half-period divider
  always_ff @(posedge clk_i) begin
    if (rst_i || state_q != ST_SHIFT || tick) begin
      div_q <= 8'h00;
    end else begin
      div_q <= div_q + 8'h01;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= ST_IDLE;
      eep_cs_o <= 1'b0;
      eep_sck_o <= 1'b0;
      tx_q <= '0;
      rx_q <= '0;
      cnt_q <= 6'h00;
      wr_q <= 1'b0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (req.start) begin
            state_q <= ST_SHIFT;
            eep_cs_o <= 1'b1;
            eep_sck_o <= 1'b0;
            wr_q <= req.write;
            cnt_q <= 6'h00;
            tx_q <= {req.write ? LPV_EEP_OP_WRITE : LPV_EEP_OP_READ, req.addr,
                     req.write ? req.wdata : 32'h0000_0000};
          end
        end
        ST_SHIFT: begin
          if (tick) begin
            if (!eep_sck_o) begin
              eep_sck_o <= 1'b1;
              cnt_q <= cnt_q + 6'h01;
              if (!wr_q && cnt_q >= LPV_EEP_HDR_BITS) begin
                rx_q <= {rx_q[30:0], eep_di_i};
              end
            end else begin
              eep_sck_o <= 1'b0;
              tx_q <= {tx_q[40:0], 1'b0};
              if (cnt_q == LPV_EEP_FRAME_BITS) begin
                state_q <= ST_DONE;
                eep_cs_o <= 1'b0;
              end
            end
          end
        end
        ST_DONE: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end
endmodule // lpv_eep_engine

// *** verilog/lpv_regs.sv ***
/*
  Link status, physical tuning and product data registers on classic Wishbone.
  Assumes link status inputs on the core clock and an EEPROM data pin from outside.
*/
// The implementer's own choice: the Wishbone interface to the registers.
module lpv_regs
  import lpv_pkg::*;
#(
  parameter int PD_WAIT_CYC = LPV_PD_WAIT_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [3:0] link_speed_i,
  input wire logic [5:0] link_width_i,
  input wire logic link_train_err_i,
  input wire logic link_training_i,
  input wire logic dl_active_i,
  input wire logic pd_req_i,
  output logic pd_enter_o,
  output logic [31:0] phy_layer_config0_o,
  output logic [31:0] phy_layer_config1_o,
  output logic [31:0] phy_layer_config2_o,
  input wire logic eep_di_i,
  output logic eep_cs_o,
  output logic eep_sck_o,
  output logic eep_do_o
);
  localparam logic [15:0] PD_CNT_MAX = 16'(PD_WAIT_CYC);

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wr,
                                        input logic [3:0] sel, input logic [31:0] mask);
    logic [31:0] be;
    be = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}} & mask;
    merge = (old & ~be) | (wr & be);
  endfunction

  lpv_eep_if eep ();

  logic req;
  logic wr_req;
  logic [31:0] link_q;
  logic [31:0] cfg0_q;
  logic [31:0] cfg1_q;
  logic [31:0] cfg2_q;
  logic op_flag_q;
  logic [5:0] vpd_addr_q;
  logic [31:0] data_q;
  logic start_q;
  logic di_sync;
  logic [15:0] pd_cnt_q;
  logic [31:0] rd_d;

  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_req = req && wb_we_i;

  // Bus acknowledge, one cycle after request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req;
    end
  end

  // Link state capture
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      link_q <= '0;
      link_q[LPV_SPEED_LSB +: 4] <= LPV_SPEED_RST;
      link_q[LPV_WIDTH_LSB +: 6] <= LPV_WIDTH_RST;
      link_q[LPV_SLOT_CLK_BIT] <= 1'b1;
    end else begin
      link_q[LPV_SPEED_LSB +: 4] <= link_speed_i;
      link_q[LPV_WIDTH_LSB +: 6] <= link_width_i;
      link_q[LPV_TRAIN_ERR_BIT] <= link_train_err_i;
      link_q[LPV_TRAINING_BIT] <= link_training_i;
      link_q[LPV_DL_INACTIVE_BIT] <= !dl_active_i;
    end
  end

  // Physical tuning words
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg0_q <= LPV_CFG0_RST;
      cfg1_q <= LPV_CFG1_RST;
      cfg2_q <= LPV_CFG2_RST;
    end else if (wr_req) begin
      if (wb_adr_i == LPV_OFS_CFG0) begin
        cfg0_q <= merge(cfg0_q, wb_dat_i, wb_sel_i, 32'hFFFF_FFFF);
      end
      if (wb_adr_i == LPV_OFS_CFG1) begin
        cfg1_q <= merge(cfg1_q, wb_dat_i, wb_sel_i, 32'hFFFF_FFFF);
      end
      if (wb_adr_i == LPV_OFS_CFG2) begin
        cfg2_q <= merge(cfg2_q, wb_dat_i, wb_sel_i, LPV_CFG2_WMASK);
      end
    end
  end

  assign phy_layer_config0_o = cfg0_q;
  assign phy_layer_config1_o = cfg1_q;
  assign phy_layer_config2_o = cfg2_q;

  // Power-down entry, optionally after a fixed wait
  always_ff @(posedge clk_i) begin
    if (rst_i || !pd_req_i) begin
      pd_cnt_q <= 16'h0000;
      pd_enter_o <= 1'b0;
    end else if (!cfg2_q[LPV_PD_WAIT_BIT]) begin
      pd_enter_o <= 1'b1;
    end else if (pd_cnt_q == PD_CNT_MAX) begin
      pd_enter_o <= 1'b1;
    end else begin
      pd_cnt_q <= pd_cnt_q + 16'h0001;
    end
  end

  // Product data control word and EEPROM start
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      op_flag_q <= 1'b0;
      vpd_addr_q <= 6'h00;
      start_q <= 1'b0;
    end else begin
      start_q <= 1'b0;
      if (eep.done) begin
        op_flag_q <= !op_flag_q;
      end else if (wr_req && wb_adr_i == LPV_OFS_CAP && wb_sel_i[3] && !eep.busy
                   && !start_q) begin
        op_flag_q <= wb_dat_i[LPV_OP_BIT];
        if (wb_sel_i[2]) begin
          vpd_addr_q <= wb_dat_i[LPV_ADDR_MSB:LPV_ADDR_LSB];
        end
        start_q <= 1'b1;
      end else if (wr_req && wb_adr_i == LPV_OFS_CAP && wb_sel_i[2] && !eep.busy
                   && !start_q) begin
        vpd_addr_q <= wb_dat_i[LPV_ADDR_MSB:LPV_ADDR_LSB];
      end
    end
  end

  assign eep.start = start_q;
  assign eep.write = op_flag_q;
  assign eep.addr = LPV_EEP_BASE + {vpd_addr_q, 2'b00};
  assign eep.wdata = data_q;

  // Data word, loaded by software or by a finished read
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      data_q <= LPV_DATA_RST;
    end else if (eep.done && !op_flag_q) begin
      data_q <= eep.rdata;
    end else if (wr_req && wb_adr_i == LPV_OFS_DATA && !eep.busy) begin
      data_q <= merge(data_q, wb_dat_i, wb_sel_i, 32'hFFFF_FFFF);
    end
  end

  // Read multiplexer
  always_comb begin
    rd_d = 32'h0000_0000;
    unique case (wb_adr_i)
      LPV_OFS_LINK: rd_d = link_q;
      LPV_OFS_CFG0: rd_d = cfg0_q;
      LPV_OFS_CFG1: rd_d = cfg1_q;
      LPV_OFS_CFG2: rd_d = cfg2_q & LPV_CFG2_WMASK;
      LPV_OFS_CAP: begin
        rd_d[7:0] = LPV_CAP_ID;
        rd_d[15:8] = LPV_NEXT_PTR;
        rd_d[LPV_ADDR_MSB:LPV_ADDR_LSB] = vpd_addr_q;
        rd_d[LPV_OP_BIT] = op_flag_q;
      end
      LPV_OFS_DATA, LPV_OFS_DATA_ALIAS: rd_d = data_q;
      default: rd_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (req && !wb_we_i) begin
      wb_dat_o <= rd_d;
    end
  end

  lpv_sync3 u_di_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .async_i(eep_di_i),
    .sync_o(di_sync)
  );

  lpv_eep_engine u_engine (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .req(eep),
    .eep_di_i(di_sync),
    .eep_cs_o(eep_cs_o),
    .eep_sck_o(eep_sck_o),
    .eep_do_o(eep_do_o)
  );
endmodule // lpv_regs

// *** dv/lpv_regs_asserts.sv ***
/*
  Port-level assertions for the register slice and its serial pins.
  Assumes it is bound onto lpv_regs with the same wait parameter.
*/
module lpv_regs_asserts
  import lpv_pkg::*;
#(
  parameter int PD_WAIT_CYC = LPV_PD_WAIT_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic pd_req_i,
  input wire logic pd_enter_o,
  input wire logic [31:0] phy_layer_config0_o,
  input wire logic [31:0] phy_layer_config1_o,
  input wire logic [31:0] phy_layer_config2_o,
  input wire logic eep_cs_o,
  input wire logic eep_sck_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic sck_q;
  logic [5:0] rise_cnt_q;
  logic [7:0] req_cnt_q;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  always_ff @(posedge clk_i) begin
    sck_q <= eep_sck_o;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i || !eep_cs_o) rise_cnt_q <= 6'h00;
    else if (eep_sck_o && !sck_q) rise_cnt_q <= rise_cnt_q + 6'h01;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i || !pd_req_i) req_cnt_q <= 8'h00;
    else if (req_cnt_q != 8'hFF) req_cnt_q <= req_cnt_q + 8'h01;
  end
  sequence req_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence sck_high_s;
    eep_sck_o [*8] ##1 eep_sck_o [*2] ##1 !eep_sck_o;
  endsequence
  ack_latency_a: assert property (req_s |=> wb_ack_o)
    else $error("ack missing after request");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  cap_read_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i == LPV_OFS_CAP
    |-> wb_dat_o[15:0] == 16'hF003) else $error("capability bytes wrong");
  unmapped_read_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'hC4
    |-> wb_dat_o == 32'h0000_0000) else $error("unmapped read not zero");
  cfg_reset_a: assert property ($past(rst_i) |-> phy_layer_config0_o == 32'h0400_1060
    && phy_layer_config1_o == 32'h0400_0800 && phy_layer_config2_o == 32'h0099_8254)
    else $error("config reset value wrong");
  top_byte_a: assert property (phy_layer_config2_o[31:24] == 8'h00)
    else $error("reserved byte set");
  pd_direct_a: assert property (!phy_layer_config2_o[23] && pd_req_i |=> pd_enter_o)
    else $error("power-down late");
  pd_wait_a: assert property (phy_layer_config2_o[23] && pd_enter_o
    |-> req_cnt_q >= PD_WAIT_CYC) else $error("power-down too early");
  cs_frame_a: assert property ($fell(eep_cs_o) |-> rise_cnt_q == 6'h2A)
    else $error("frame length wrong");
  sck_half_a: assert property ($rose(eep_sck_o) |-> sck_high_s)
    else $error("serial clock half period wrong");
endmodule // lpv_regs_asserts

// *** dv/lpv_eep_model.sv ***
/*
  Serial EEPROM model: 64 words, takes opcode and address, stores or returns data.
  Assumes cs and sck sampled on the core clock.
*/
module lpv_eep_model
  import lpv_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cs_i,
  input wire logic sck_i,
  input wire logic do_i,
  output logic di_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [31:0] mem [64];
  logic sck_q;
  logic [5:0] cnt_q;
  logic [9:0] hdr_q;
  logic [31:0] sh_q;
  logic [5:0] idx;
  assign idx = 6'((hdr_q[7:0] - LPV_EEP_BASE) >> 2);
  always_ff @(posedge clk_i) begin
    sck_q <= sck_i;
    if (rst_i) begin
      cnt_q <= 6'h00;
      di_o <= 1'b0;
      for (int i = 0; i < 64; i++) mem[i] <= 32'hC3A5_0000 + i;
    end else if (!cs_i) begin
      cnt_q <= 6'h00;
      di_o <= ~di_o;
    end else if (sck_i && !sck_q) begin
      cnt_q <= cnt_q + 6'h01;
      if (cnt_q < 6'h0A) hdr_q <= {hdr_q[8:0], do_i};
      else sh_q <= {sh_q[30:0], do_i};
      if (cnt_q == 6'h29 && hdr_q[9:8] == LPV_EEP_OP_WRITE) mem[idx] <= {sh_q[30:0], do_i};
    end else if (!sck_i && sck_q && cnt_q >= 6'h0A && cnt_q < 6'h2A) begin
      di_o <= mem[idx][6'h29 - cnt_q];
    end
  end
endmodule // lpv_eep_model

// *** dv/link_phy_vpd_config_regs_tb.sv ***
/*
  Self-checking bench for lpv_regs with the EEPROM model on its serial pins.
  Assumes one 125 MHz clock and the package constants.
*/
module link_phy_vpd_config_regs_tb
  import lpv_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int PD = 5;
  typedef struct packed {
    logic we;
    logic [7:0] adr;
    logic [31:0] d;
    logic [3:0] sel;
    logic [31:0] exp;
  } lpv_row_type;
  lpv_row_type rows [12] = '{
    '{1'b0, 8'hC0, 32'h0, 4'hF, 32'h3841_0000}, '{1'b0, 8'hCC, 32'h0, 4'hF, 32'h0400_1060},
    '{1'b0, 8'hD0, 32'h0, 4'hF, 32'h0400_0800}, '{1'b0, 8'hD4, 32'h0, 4'hF, 32'h0099_8254},
    '{1'b0, 8'hD8, 32'h0, 4'hF, 32'h0000_F003}, '{1'b0, 8'hDC, 32'h0, 4'hF, 32'h0},
    '{1'b1, 8'hC4, 32'hFFFF_FFFF, 4'hF, 32'h0}, '{1'b1, 8'hC0, 32'hFFFF_FFFF, 4'hF, 32'h3841_0000},
    '{1'b1, 8'hCC, 32'hFFFF_FFFF, 4'hF, 32'hFFFF_FFFF},
    '{1'b1, 8'hD0, 32'h1234_5678, 4'h5, 32'h0434_0878},
    '{1'b1, 8'hD4, 32'hFFFF_FFFF, 4'hF, 32'h00FF_FFFF},
    '{1'b1, 8'hD8, 32'hFFFF_FFFF, 4'h3, 32'h0000_F003}};
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, pd_req_i, pd_enter_o;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i, link_speed_i;
  logic [31:0] wb_dat_i, wb_dat_o, cfg0, cfg1, cfg2, r;
  logic [5:0] link_width_i;
  logic link_train_err_i, link_training_i, dl_active_i, eep_di_i, eep_cs_o, eep_sck_o, eep_do_o;
  int fails = 0;
  int check_count = 0;
  lpv_regs #(.PD_WAIT_CYC(PD)) dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .link_speed_i(link_speed_i),
    .link_width_i(link_width_i), .link_train_err_i(link_train_err_i),
    .link_training_i(link_training_i), .dl_active_i(dl_active_i), .pd_req_i(pd_req_i),
    .pd_enter_o(pd_enter_o), .phy_layer_config0_o(cfg0), .phy_layer_config1_o(cfg1),
    .phy_layer_config2_o(cfg2), .eep_di_i(eep_di_i), .eep_cs_o(eep_cs_o),
    .eep_sck_o(eep_sck_o), .eep_do_o(eep_do_o));
  lpv_eep_model u_eep (.clk_i(clk_i), .rst_i(rst_i), .cs_i(eep_cs_o), .sck_i(eep_sck_o),
    .do_i(eep_do_o), .di_o(eep_di_i));
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  task results;
    $display("Checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'b11, w, a, d, s};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (wb_ack_o !== 1'b1) begin
      fails++;
      results();
    end
    r = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask
  task eep_wait(input logic flag);
    int n;
    n = 0;
    do begin
      wb(1'b0, LPV_OFS_CAP, 32'h0, 4'hF);
      if (n == 0) chk(r[31], !flag);
      n++;
    end while (r[31] !== flag && n < 1000);
    if (n >= 1000) begin
      fails++;
      results();
    end
  endtask
  task pd_test(input int exp_n);
    int n;
    @(posedge clk_i);
    pd_req_i <= 1'b1;
    n = 0;
    @(negedge clk_i);
    while (pd_enter_o !== 1'b1 && n < 50) begin
      @(negedge clk_i);
      n++;
    end
    chk(n, exp_n);
    @(posedge clk_i);
    pd_req_i <= 1'b0;
    @(posedge clk_i);
    @(negedge clk_i);
    chk(pd_enter_o, 1'b0);
  endtask
  initial begin
    rst_i = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} = '0;
    {link_speed_i, link_width_i, link_train_err_i} = {4'h1, 6'h04, 1'b0};
    {link_training_i, dl_active_i, pd_req_i} = 3'b100;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (rows[i]) begin
      if (rows[i].we) wb(1'b1, rows[i].adr, rows[i].d, rows[i].sel);
      wb(1'b0, rows[i].adr, 32'h0, 4'hF);
      chk(r, rows[i].exp);
    end
    chk(cfg0, 32'hFFFF_FFFF);
    chk(cfg1, 32'h0434_0878);
    chk(cfg2, 32'h00FF_FFFF);
    $display("Table test done");
    @(posedge clk_i);
    {link_speed_i, link_width_i, link_train_err_i, link_training_i, dl_active_i} <=
      {4'h2, 6'h01, 3'b101};
    wb(1'b0, LPV_OFS_LINK, 32'h0, 4'hF);
    chk(r, 32'h1412_0000);
    $display("Link test done");
    pd_test(PD + 1);
    wb(1'b1, LPV_OFS_CFG2, 32'h0, 4'h4);
    pd_test(1);
    $display("Power test done");
    wb(1'b1, LPV_OFS_DATA, 32'hDEAD_BEEF, 4'hF);
    wb(1'b1, LPV_OFS_CAP, 32'h8014_0000, 4'hC);
    eep_wait(1'b0);
    wb(1'b1, LPV_OFS_DATA, 32'h0, 4'hF);
    wb(1'b1, LPV_OFS_CAP, 32'h0014_0000, 4'hC);
    eep_wait(1'b1);
    wb(1'b0, LPV_OFS_DATA_ALIAS, 32'h0, 4'hF);
    chk(r, 32'hDEAD_BEEF);
    wb(1'b1, LPV_OFS_CAP, 32'h001C_0000, 4'hC);
    wb(1'b1, LPV_OFS_CAP, 32'h8000_0000, 4'hC);
    eep_wait(1'b1);
    chk(r, 32'h801C_F003);
    wb(1'b0, LPV_OFS_DATA, 32'h0, 4'hF);
    chk(r, 32'hC3A5_0007);
    $display("EEPROM test done");
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, LPV_OFS_CFG0, 32'h0, 4'hF);
    chk(r, 32'h0400_1060);
    $display("Reset test done");
    results();
  end
endmodule // link_phy_vpd_config_regs_tb
bind lpv_regs lpv_regs_asserts #(.PD_WAIT_CYC(PD_WAIT_CYC)) u_chk (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pd_req_i(pd_req_i), .pd_enter_o(pd_enter_o),
  .phy_layer_config0_o(phy_layer_config0_o), .phy_layer_config1_o(phy_layer_config1_o),
  .phy_layer_config2_o(phy_layer_config2_o), .eep_cs_o(eep_cs_o), .eep_sck_o(eep_sck_o));
